// ---- avc_addr.sv ----
/*
  Address stepper: advances the sector address across CHS geometry or
  flat LBA. Assumes geometry inputs are stable during a command.
*/
`timescale 1ns/1ps
module avc_addr (
  // Current address
  input  wire logic        lba_mode,
  input  wire logic [7:0]  sect_in,
  input  wire logic [15:0] cyl_in,
  input  wire logic [3:0]  head_in,
  // Geometry
  input  wire logic [7:0]  sect_per_trk,
  input  wire logic [3:0]  heads_max,
  // Next address
  output logic [7:0]  sect_out,
  output logic [15:0] cyl_out,
  output logic [3:0]  head_out
);
  logic [27:0] lba_n;
  always_comb begin
    lba_n = avc_pkg::avc_lba_inc({head_in, cyl_in, sect_in});
    sect_out = sect_in;
    cyl_out = cyl_in;
    head_out = head_in;
    if (lba_mode) begin
      {head_out, cyl_out, sect_out} = lba_n;
    end else if (sect_in < sect_per_trk) begin
      sect_out = sect_in + 8'h01;
    end else begin
      // Sector numbers start at one in CHS
      sect_out = 8'h01;
      if (head_in < heads_max) begin
        head_out = head_in + 4'h1;
      end else begin
        head_out = 4'h0;
        cyl_out = cyl_in + 16'h0001;
      end
    end
  end
endmodule

// ---- avc_cmd_dec.sv ----
/*
  Opcode decoder for the command engine. Assumes the opcode is held
  stable in the cycle its strobe is high.
*/
`timescale 1ns/1ps
module avc_cmd_dec (
  // Opcode
  input  wire logic [7:0] opcode,
  // Decoded kind
  output logic            is_verify,
  output logic            retry_en,
  output logic            is_recal,
  output logic            is_seek
);
  always_comb begin
    is_verify = (opcode == avc_pkg::OP_VERIFY_RETRY) ||
                (opcode == avc_pkg::OP_VERIFY_NORETRY);
    retry_en = (opcode == avc_pkg::OP_VERIFY_RETRY);
    is_recal = (opcode[7:4] == avc_pkg::OP_RECAL_NIB);
    is_seek = (opcode[7:4] == avc_pkg::OP_SEEK_NIB);
  end
endmodule

// ---- avc_engine.sv ----
/*
  Verify / recalibrate / seek command engine. Takes a command strobe with
  the task-file contents, reads sectors through a flash read port with an
  ECC verdict, and writes back address, count, status and error.
  Assumes the host has loaded the task file before the command (count,
  sector, cylinders, device/head) and that the flash port answers every
  request with one done pulse.
*/
`timescale 1ns/1ps
module avc_engine (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  input  wire logic        soft_rst,
  // Command from task file
  input  wire logic        cmd_stb,
  input  wire logic [7:0]  cmd_op,
  input  wire logic [7:0]  tf_count,
  input  wire logic [7:0]  tf_sector,
  input  wire logic [15:0] tf_cyl,
  input  wire logic [7:0]  tf_devhead,
  // Geometry
  input  wire logic [7:0]  sect_per_trk,
  input  wire logic [3:0]  heads_max,
  // Flash sector read port
  output logic             fl_req,
  output logic [27:0]      fl_addr,
  output logic             fl_retry,
  input  wire logic        fl_done,
  input  wire logic        fl_ecc_ok,
  input  wire logic        fl_corrected,
  // Task-file write-back
  output logic             tf_wr,
  output logic [7:0]       out_count,
  output logic [7:0]       out_sector,
  output logic [15:0]      out_cyl,
  output logic [7:0]       out_devhead,
  output logic [7:0]       status_q,
  output logic [7:0]       error_q,
  output logic             intrq_q,
  output logic             data_req
);
  avc_pkg::avc_state_t st_q;
  logic        is_verify;
  logic        retry_en;
  logic        is_recal;
  logic        is_seek;
  logic        lba_q;
  logic        retry_q;
  logic [7:0]  left_q;
  logic [7:0]  sect_q;
  logic [15:0] cyl_q;
  logic [3:0]  head_q;
  logic [3:0]  dh_hi_q;
  logic [7:0]  sect_n;
  logic [15:0] cyl_n;
  logic [3:0]  head_n;
  logic [3:0]  wait_q;
  logic        fail_q;
  logic        corr_q;
  logic        rst;

  assign rst = sys_rst | soft_rst;

  avc_cmd_dec u_dec (
    .opcode    (cmd_op),
    .is_verify (is_verify),
    .retry_en  (retry_en),
    .is_recal  (is_recal),
    .is_seek   (is_seek)
  );

  avc_addr u_addr (
    .lba_mode     (lba_q),
    .sect_in      (sect_q),
    .cyl_in       (cyl_q),
    .head_in      (head_q),
    .sect_per_trk (sect_per_trk),
    .heads_max    (heads_max),
    .sect_out     (sect_n),
    .cyl_out      (cyl_n),
    .head_out     (head_n)
  );

  // No data ever leaves this engine
  assign data_req = 1'b0;
  assign fl_req = (st_q == avc_pkg::AVC_REQ);
  assign fl_addr = {head_q, cyl_q, sect_q};
  assign fl_retry = retry_q;
  assign out_count = left_q;
  assign out_sector = sect_q;
  assign out_cyl = cyl_q;
  assign out_devhead = {dh_hi_q, head_q};

  // Sequencer
  always_ff @(posedge mclk) begin
    if (rst) begin
      st_q <= avc_pkg::AVC_IDLE;
    end else begin
      unique case (st_q)
        avc_pkg::AVC_IDLE: begin
          if (cmd_stb && is_verify) begin
            st_q <= avc_pkg::AVC_REQ;
          end else if (cmd_stb && (is_seek || is_recal)) begin
            st_q <= avc_pkg::AVC_SEEK;
          end else if (cmd_stb) begin
            st_q <= avc_pkg::AVC_DONE;
          end
        end
        avc_pkg::AVC_REQ: begin
          st_q <= avc_pkg::AVC_WAIT;
        end
        avc_pkg::AVC_WAIT: begin
          if (fl_done && !fl_ecc_ok) begin
            st_q <= avc_pkg::AVC_DONE;
          end else if (fl_done) begin
            st_q <= avc_pkg::AVC_NEXT;
          end
        end
        avc_pkg::AVC_NEXT: begin
          if (left_q == 8'h00) begin
            st_q <= avc_pkg::AVC_DONE;
          end else begin
            st_q <= avc_pkg::AVC_REQ;
          end
        end
        avc_pkg::AVC_SEEK: begin
          if (wait_q == 4'h0) begin
            st_q <= avc_pkg::AVC_DONE;
          end
        end
        avc_pkg::AVC_DONE: begin
          st_q <= avc_pkg::AVC_IDLE;
        end
        default: begin
          st_q <= avc_pkg::AVC_IDLE;
        end
      endcase
    end
  end

  // Address and count tracking
  always_ff @(posedge mclk) begin
    if (rst) begin
      lba_q <= 1'b0;
      retry_q <= 1'b0;
      left_q <= 8'h00;
      sect_q <= 8'h00;
      cyl_q <= 16'h0000;
      head_q <= 4'h0;
      dh_hi_q <= 4'h0;
    end else if (st_q == avc_pkg::AVC_IDLE && cmd_stb) begin
      lba_q <= tf_devhead[avc_pkg::DH_LBA];
      retry_q <= retry_en;
      dh_hi_q <= tf_devhead[7:4];
      head_q <= tf_devhead[3:0];
      left_q <= tf_count;
      if (is_recal) begin
        cyl_q <= 16'h0000;
        head_q <= 4'h0;
        sect_q <= tf_devhead[avc_pkg::DH_LBA] ? 8'h00
                  : avc_pkg::RECAL_CHS_SECTOR;
      end else begin
        sect_q <= tf_sector;
        cyl_q <= tf_cyl;
      end
    end else if (st_q == avc_pkg::AVC_WAIT && fl_done && fl_ecc_ok) begin
      // Zero count means 256 sectors; wrap gives 255 left
      left_q <= left_q - 8'h01;
    end else if (st_q == avc_pkg::AVC_NEXT && left_q != 8'h00) begin
      // Only step past a sector once it passed, so last stays put
      sect_q <= sect_n;
      cyl_q <= cyl_n;
      head_q <= head_n;
    end
  end

  // Seek settle timer
  always_ff @(posedge mclk) begin
    if (rst) begin
      wait_q <= 4'h0;
    end else if (st_q == avc_pkg::AVC_IDLE && cmd_stb) begin
      wait_q <= avc_pkg::SEEK_CYC;
    end else if (st_q == avc_pkg::AVC_SEEK && wait_q != 4'h0) begin
      wait_q <= wait_q - 4'h1;
    end
  end

  // Outcome flags
  always_ff @(posedge mclk) begin
    if (rst) begin
      fail_q <= 1'b0;
      corr_q <= 1'b0;
    end else if (st_q == avc_pkg::AVC_IDLE && cmd_stb) begin
      fail_q <= 1'b0;
      corr_q <= 1'b0;
    end else if (st_q == avc_pkg::AVC_WAIT && fl_done) begin
      fail_q <= !fl_ecc_ok;
      corr_q <= corr_q | fl_corrected;
    end
  end

  // Status, error and interrupt
  always_ff @(posedge mclk) begin
    if (rst) begin
      status_q <= avc_pkg::STATUS_RST;
      error_q <= avc_pkg::ERROR_RST;
      intrq_q <= 1'b0;
      tf_wr <= 1'b0;
    end else begin
      tf_wr <= 1'b0;
      if (st_q == avc_pkg::AVC_IDLE && cmd_stb) begin
        status_q <= 8'h00;
        status_q[avc_pkg::ST_BSY] <= 1'b1;
        error_q <= 8'h00;
        intrq_q <= 1'b0;
      end else if (st_q == avc_pkg::AVC_DONE) begin
        status_q <= 8'h00;
        status_q[avc_pkg::ST_DRDY] <= 1'b1;
        status_q[avc_pkg::ST_DSC] <= 1'b1;
        status_q[avc_pkg::ST_CORR] <= corr_q;
        intrq_q <= 1'b1;
        tf_wr <= 1'b1;
        if (!is_verify_q_ok()) begin
          status_q[avc_pkg::ST_ERR] <= 1'b1;
          error_q[avc_pkg::ER_ABRT] <= 1'b1;
        end else if (fail_q) begin
          status_q[avc_pkg::ST_ERR] <= 1'b1;
          error_q[avc_pkg::ER_UNC] <= 1'b1;
        end
      end
    end
  end

  // Unsupported opcode lands in DONE without a verify or seek pass
  logic known_q;
  always_ff @(posedge mclk) begin
    if (rst) begin
      known_q <= 1'b1;
    end else if (st_q == avc_pkg::AVC_IDLE && cmd_stb) begin
      known_q <= is_verify | is_seek | is_recal;
    end
  end

  function automatic logic is_verify_q_ok();
    return known_q;
  endfunction
endmodule

// ---- avc_flash_model.sv ----
/*
  Flash read port model: answers each read lat + 2 cycles after the request and
  fails the ECC check on bad_addr only. Lat and bad_addr come from tb.
*/
`timescale 1ns/1ps
module avc_flash_model (
  input  wire logic        mclk,
  input  wire logic        fl_req,
  input  wire logic [27:0] fl_addr,
  input  wire logic [27:0] bad_addr,
  input  wire logic [3:0]  lat,
  output logic             fl_done,
  output logic             fl_ecc_ok,
  output logic             fl_corrected
);
  logic [3:0]  cnt_q = 4'h0;
  logic [27:0] addr_q;
  logic        busy_q = 1'b0;
  initial fl_done = 1'b0;
  initial fl_ecc_ok = 1'b0;
  initial fl_corrected = 1'b0;
  // Verdict lines toggle between answers so a stale value is not trusted
  always @(posedge mclk) begin
    fl_done <= 1'b0;
    fl_ecc_ok <= ~fl_ecc_ok;
    fl_corrected <= ~fl_corrected;
    if (fl_req) begin
      busy_q <= 1'b1;
      addr_q <= fl_addr;
      cnt_q <= lat;
    end else if (busy_q && cnt_q != 4'h0) begin
      cnt_q <= cnt_q - 4'h1;
    end else if (busy_q) begin
      busy_q <= 1'b0;
      fl_done <= 1'b1;
      fl_ecc_ok <= addr_q != bad_addr;
      fl_corrected <= 1'b0;
    end
  end
endmodule

// ---- avc_pkg.sv ----
/*
  Shared constants for the verify / recalibrate / seek command engine:
  opcodes, status and error bit positions, reset values, timing.
  Assumes the task-file registers live outside and are loaded by the
  engine's load strobes.
*/
// Overview of operation
// - 40h verifies with retries, 41h without.
// - Verify reads and checks ECC, no data.
// - Busy set on accept, held while checking.
// - After last sector, clear busy, raise interrupt.
// - Success leaves address of last checked sector.
// - Failure stops, loads failing sector's address.
// - Failure loads count of unchecked sectors.
// - 1Xh recalibrates; CHS clears address, sector=1.
// - LBA recalibrate clears all address fields.
// - 7Xh seeks to current task-file address.
// - Data moves only while data request asserted.
package avc_pkg;
  localparam logic [7:0] OP_VERIFY_RETRY   = 8'h40;
  localparam logic [7:0] OP_VERIFY_NORETRY = 8'h41;
  localparam logic [3:0] OP_RECAL_NIB      = 4'h1;
  localparam logic [3:0] OP_SEEK_NIB       = 4'h7;
  localparam int ST_BSY  = 7;
  localparam int ST_DRDY = 6;
  localparam int ST_DF   = 5;
  localparam int ST_DSC  = 4;
  localparam int ST_DRQ  = 3;
  localparam int ST_CORR = 2;
  localparam int ST_ERR  = 0;
  localparam int ER_UNC  = 6;
  localparam int ER_IDNF = 4;
  localparam int ER_ABRT = 2;
  localparam int DH_LBA  = 6;
  localparam logic [7:0] STATUS_RST = 8'h50;
  localparam logic [7:0] ERROR_RST  = 8'h00;
  localparam logic [7:0] RECAL_CHS_SECTOR = 8'h01;
  localparam int SEEK_TIME_NS = 40;
  localparam int CLK_PERIOD_NS = 4;
  localparam int SEEK_CYCLES = (SEEK_TIME_NS + CLK_PERIOD_NS - 1)
                               / CLK_PERIOD_NS;
  localparam logic [3:0] SEEK_CYC = 4'(SEEK_CYCLES);
  typedef enum logic [2:0] {
    AVC_IDLE = 3'b000,
    AVC_REQ  = 3'b001,
    AVC_WAIT = 3'b011,
    AVC_NEXT = 3'b010,
    AVC_SEEK = 3'b110,
    AVC_DONE = 3'b100
  } avc_state_t;
  // Next address in flat LBA order; used by avc_addr for LBA-mode stepping only
  function automatic logic [27:0] avc_lba_inc(input logic [27:0] a);
    return a + 28'h0000001;
  endfunction
endpackage

// ---- avc_properties.sv ----
/*
  Checker for the command engine: busy, completion, addressing, abort.
  Bound to every avc_engine instance; sees that module's ports only.
*/
`timescale 1ns/1ps
module avc_properties (
  input wire logic        mclk,
  input wire logic        sys_rst,
  input wire logic        soft_rst,
  input wire logic        cmd_stb,
  input wire logic [7:0]  cmd_op,
  input wire logic [7:0]  tf_devhead,
  input wire logic        fl_req,
  input wire logic        fl_retry,
  input wire logic        fl_done,
  input wire logic        fl_ecc_ok,
  input wire logic        tf_wr,
  input wire logic [7:0]  out_sector,
  input wire logic [15:0] out_cyl,
  input wire logic [7:0]  out_devhead,
  input wire logic [7:0]  status_q,
  input wire logic [7:0]  error_q,
  input wire logic        intrq_q,
  input wire logic        data_req
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst || soft_rst);
  wire idle = cmd_stb && !status_q[7];
  wire vfy  = cmd_op[7:1] == 7'h20;
  wire rcl  = cmd_op[7:4] == 4'h1;
  wire unk  = !vfy && !rcl && cmd_op[7:4] != 4'h7;
  sequence s_fin;
    ##[1:20] tf_wr;
  endsequence
  a_no_data_req: assert property (!data_req)
    else $error("data request raised");
  a_verify_accept: assert property (
    idle && vfy |=> status_q[7] && fl_req
    && fl_retry == !$past(cmd_op[0])) else $error("verify not taken");
  a_req_busy: assert property (fl_req |-> status_q[7])
    else $error("read while not busy");
  a_done_flags: assert property (tf_wr |->
    !status_q[7] && intrq_q && status_q[6] && status_q[4]
    && !status_q[5] && !status_q[3]) else $error("bad completion flags");
  a_ecc_fail: assert property (fl_done && !fl_ecc_ok && status_q[7]
    |-> ##[1:3] tf_wr && status_q == 8'h51 && error_q == 8'h40)
    else $error("ecc failure not reported");
  a_recal_chs: assert property (
    idle && rcl && !tf_devhead[6] |-> s_fin
    ##0 {out_devhead[3:0], out_cyl, out_sector} == 28'h0000001)
    else $error("chs recal address");
  a_recal_lba: assert property (
    idle && rcl && tf_devhead[6] |-> s_fin
    ##0 {out_devhead[3:0], out_cyl, out_sector} == 28'h0000000)
    else $error("lba recal address");
  a_seek_ok: assert property (idle && cmd_op[7:4] == 4'h7
    |-> ##[12:14] tf_wr && status_q == 8'h50) else $error("seek end");
  a_unknown_abort: assert property (idle && unk |-> ##[1:3] tf_wr
    && status_q == 8'h51 && error_q == 8'h04) else $error("no abort");
  a_intrq_held: assert property (intrq_q && !cmd_stb |=> intrq_q)
    else $error("interrupt dropped");
endmodule
bind avc_engine avc_properties u_props (
  .mclk        (mclk),
  .sys_rst     (sys_rst),
  .soft_rst    (soft_rst),
  .cmd_stb     (cmd_stb),
  .cmd_op      (cmd_op),
  .tf_devhead  (tf_devhead),
  .fl_req      (fl_req),
  .fl_retry    (fl_retry),
  .fl_done     (fl_done),
  .fl_ecc_ok   (fl_ecc_ok),
  .tf_wr       (tf_wr),
  .out_sector  (out_sector),
  .out_cyl     (out_cyl),
  .out_devhead (out_devhead),
  .status_q    (status_q),
  .error_q     (error_q),
  .intrq_q     (intrq_q),
  .data_req    (data_req)
);

// ---- tb.sv ----
/*
  Testbench for avc_engine: random verifies, a failing sector,
  recalibrate, seek, an unknown opcode, a track wrap in CHS and a
  soft reset in mid-command. Flash port is modelled.
*/
`timescale 1ns/1ps
module tb;
  logic        mclk, sys_rst, soft_rst, cmd_stb, fl_req, fl_retry;
  logic        fl_done, fl_ecc_ok, fl_corrected, tf_wr, intrq_q, data_req;
  logic [7:0]  cmd_op, tf_count, tf_sector, tf_devhead, out_count, c;
  logic [7:0]  out_sector, out_devhead, status_q, error_q;
  logic [15:0] tf_cyl, out_cyl;
  logic [27:0] fl_addr, bad_addr, a;
  logic [3:0]  lat;
  wire  [27:0] addr_out = {out_devhead[3:0], out_cyl, out_sector};
  int          num_errors = 0;
  int          tests_run = 0;
  always #2 mclk = ~mclk;
  avc_engine uut (
    .mclk         (mclk),
    .sys_rst      (sys_rst),
    .soft_rst     (soft_rst),
    .cmd_stb      (cmd_stb),
    .cmd_op       (cmd_op),
    .tf_count     (tf_count),
    .tf_sector    (tf_sector),
    .tf_cyl       (tf_cyl),
    .tf_devhead   (tf_devhead),
    .sect_per_trk (8'h20),
    .heads_max    (4'hf),
    .fl_req       (fl_req),
    .fl_addr      (fl_addr),
    .fl_retry     (fl_retry),
    .fl_done      (fl_done),
    .fl_ecc_ok    (fl_ecc_ok),
    .fl_corrected (fl_corrected),
    .tf_wr        (tf_wr),
    .out_count    (out_count),
    .out_sector   (out_sector),
    .out_cyl      (out_cyl),
    .out_devhead  (out_devhead),
    .status_q     (status_q),
    .error_q      (error_q),
    .intrq_q      (intrq_q),
    .data_req     (data_req)
  );
  avc_flash_model fm (
    .mclk         (mclk),
    .fl_req       (fl_req),
    .fl_addr      (fl_addr),
    .bad_addr     (bad_addr),
    .lat          (lat),
    .fl_done      (fl_done),
    .fl_ecc_ok    (fl_ecc_ok),
    .fl_corrected (fl_corrected)
  );
  function automatic logic [27:0] last(input logic [27:0] s,
                                       input logic [7:0] n);
    return s + (n == 8'h00 ? 28'h100 : 28'(n)) - 28'h1;
  endfunction
  task automatic chk(input logic [27:0] seen, input logic [27:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic run(input logic [7:0] op, input logic [7:0] n,
                     input logic [27:0] s, input logic lba);
    int k = 0;
    cmd_op = op;
    tf_count = n;
    tf_sector = s[7:0];
    tf_cyl = s[23:8];
    tf_devhead = {1'b1, lba, 2'b10, s[27:24]};
    cmd_stb = 1'b1;
    @(posedge mclk);
    #1 cmd_stb = 1'b0;
    while (tf_wr !== 1'b1 && k < 4000) begin
      @(posedge mclk);
      #1 k++;
    end
    chk(k < 4000, 1'b1);
  endtask
  task automatic results;
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #100000 num_errors++;
    $display("unexpected at %0t: watchdog", $time);
    results;
  end
  initial begin
    mclk = 1'b0;
    {sys_rst, soft_rst, cmd_stb, cmd_op, tf_count} = 19'h40000;
    {tf_sector, tf_cyl, tf_devhead, lat} = 36'h0;
    bad_addr = '1;
    void'($urandom(32'haf78));
    repeat (20) @(posedge mclk);
    #1 sys_rst = 1'b0;
    for (int i = 0; i < 8; i++) begin
      a = 28'($urandom_range(0, 32'h0fff0000));
      c = i == 0 ? 8'h00 : 8'($urandom_range(1, 6));
      lat = 4'($urandom_range(0, 9));
      run(i[0] ? 8'h41 : 8'h40, c, a, 1'b1);
      chk(addr_out, last(a, c));
      chk({status_q, error_q, intrq_q, data_req}, 18'h14002);
      $display("verify test %0d done", i);
    end
    a = 28'h0123456;
    bad_addr = a + 28'h2;
    run(8'h40, 8'h05, a, 1'b1);
    chk(addr_out, bad_addr);
    chk(out_count, 8'h03);
    chk({status_q, error_q}, 16'h5140);
    $display("failing verify test done");
    // Last sector of the last head wraps to sector one of the next cylinder
    run(8'h41, 8'h03, 28'hf01231f, 1'b0);
    chk(addr_out, 28'h0012401);
    chk({status_q, error_q}, 16'h5000);
    $display("chs verify test done");
    for (int m = 0; m < 2; m++) begin
      run(8'h10 | 8'($urandom_range(0, 15)), 8'h07, 28'h0abcdef, m[0]);
      chk(addr_out, m ? 28'h0 : 28'h1);
      chk({status_q, error_q}, 16'h5000);
      $display("recalibrate test %0d done", m);
    end
    a = 28'($urandom);
    run(8'h70 | 8'($urandom_range(0, 15)), 8'h01, a, 1'b1);
    chk(addr_out, a);
    chk({status_q, error_q}, 16'h5000);
    $display("seek test done");
    run(8'h55, 8'h01, a, 1'b1);
    chk({status_q, error_q}, 16'h5104);
    $display("unknown opcode test done");
    // Soft reset in mid-verify must abandon the command at once
    cmd_op = 8'h40;
    tf_count = 8'h00;
    cmd_stb = 1'b1;
    @(posedge mclk);
    #1 cmd_stb = 1'b0;
    repeat (30) @(posedge mclk);
    #1 chk(status_q[7], 1'b1);
    soft_rst = 1'b1;
    @(posedge mclk);
    #1 soft_rst = 1'b0;
    chk({status_q, error_q, intrq_q, tf_wr}, 18'h14000);
    chk(addr_out, 28'h0);
    $display("soft reset test done");
    results;
  end
endmodule
